/* File: include/ivc_pkg.sv */
// Constants shared by the interrupt vector controller and its helpers.
// Assumes one system clock; all offsets are byte addresses on the register port.
//
// Summary of operation
// - A source request is caught on the next clock edge after it reaches the clock domain and sets that vector's arrival flag.
// - The posted flag of a vector sets in the cycle after its arrival flag set.
// - Once a vector is posted, priorities are evaluated for 3 cycles before the request and vector number go to the core.
// - The winning vector's handler address is shown to the core, which acknowledges and then reads it to branch.
// - On the core acknowledge the serviced vector's arrival flag clears first and its posted flag one cycle later.
// - The acknowledge phase lasts 7 cycles while the core finishes its instruction and starts the handler.
// - When the handler returns, a service-complete pulse is raised and the active level status goes back to its earlier value.
// - Among pending vectors of equal level, the lower vector number is forwarded first.
// - Each vector takes its request from a fixed peripheral line, a DMA terminal line or a fabric line.
// - The DMA choice connects straight to the DMA terminal outputs, two per DMA channel.
// - Through the fabric choice only fabric signal n can reach vector n.
// - Vectors 0 to 15 take DMA group A bits 0 to 15, vectors 16 to 31 group B bits 0 to 15, and fabric line n feeds vector n.
// - Software gives each vector one of eight levels at run time and handlers nest across the eight levels.
// - Each vector has its own enable.
// - Software can force a vector pending and can clear a vector's pending state without service.
package ivc_pkg;
   localparam int NUM_VEC = 32;
   localparam int LVL_W = 3;
   localparam int SEL_W = 2;
   localparam int DMA_GRP = 16;
   // Register offsets.
   localparam logic [7:0] OFS_EN = 8'h00;
   localparam logic [7:0] OFS_FORCE = 8'h04;
   localparam logic [7:0] OFS_CLR = 8'h08;
   localparam logic [7:0] OFS_ARR = 8'h0c;
   localparam logic [7:0] OFS_POSTED_FLAG = 8'h10;
   localparam logic [7:0] OFS_ACT = 8'h14;
   localparam logic [7:0] OFS_EVT = 8'h18;
   localparam logic [7:0] OFS_MASK = 8'h1c;
   localparam logic [3:0] OFS_PRIO_HI = 4'h2;
   localparam logic [3:0] OFS_SEL_HI = 4'h3;
   localparam logic [1:0] SEL_REGS = 2'h2;
   // Field layout: eight level fields of four bits, sixteen select fields of two bits.
   localparam int PRIO_STRIDE = 4;
   localparam int PRIO_PER_REG = 8;
   localparam int SEL_PER_REG = 16;
   localparam int ACT_PHASE_BIT = 8;
   // Source select encodings.
   localparam logic [1:0] SRC_FIXED = 2'h0;
   localparam logic [1:0] SRC_DMA = 2'h1;
   localparam logic [1:0] SRC_FABRIC = 2'h2;
   // Event status bits.
   localparam int EVT_FWD = 0;
   localparam int EVT_ACK = 1;
   localparam int EVT_DONE = 2;
   localparam int EVT_W = 3;
   // Reset values and timing counts.
   localparam logic [31:0] EN_RST = 32'h0;
   localparam logic [3:0] LVL_NONE = 4'h8;
   localparam logic [2:0] EVAL_CYC = 3'h3;
   localparam logic [2:0] ACK_CYC = 3'h7;
   typedef enum logic [1:0] {
      IVC_IDLE = 2'b00,
      IVC_EVAL = 2'b01,
      IVC_REQ = 2'b10,
      IVC_ACK = 2'b11
   } ivc_state_t;
endpackage : ivc_pkg

/* File: include/ivc_arb_if.sv */
// Interface between the controller and its priority arbiter.
// Assumes both ends sit on the same clock; the arbiter itself is combinational.
`timescale 1ns/1ns
interface ivc_arb_if #(parameter int NV = 32, parameter int LW = 3);
   logic [NV-1:0] eligible;
   logic [NV*LW-1:0] lvl;
   logic win_valid;
   logic [$clog2(NV)-1:0] win_idx;
   modport ctl (output eligible, output lvl, input win_valid, input win_idx);
   modport arb (input eligible, input lvl, output win_valid, output win_idx);
endinterface : ivc_arb_if

/* File: rtl/ivc_prio_arb.sv */
// Picks the eligible vector with the lowest level number, lowest index on a tie.
// Assumes eligibility already holds enable, posted and nesting filters.
`timescale 1ns/1ns
module ivc_prio_arb
   import ivc_pkg::*;
(
   ivc_arb_if.arb a
);
   logic [3:0] best;
   // Scan downward so an equal level at a lower index takes over.
   always_comb begin
      best = LVL_NONE;
      a.win_valid = 1'b0;
      a.win_idx = '0;
      for (int v = NUM_VEC - 1; v >= 0; v--) begin
         if (a.eligible[v] && ({1'b0, a.lvl[v*LVL_W +: LVL_W]} <= best)) begin
            best = {1'b0, a.lvl[v*LVL_W +: LVL_W]};
            a.win_valid = 1'b1;
            a.win_idx = 5'(v);
         end
      end
   end
endmodule : ivc_prio_arb

/* File: rtl/ivc_vec_ram.sv */
// Handler address table with one write port and two registered read ports.
// Assumes the writer and both readers share the clock and clock enable.
`timescale 1ns/1ns
module ivc_vec_ram #(
   parameter int DEPTH = 32,
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [$clog2(DEPTH)-1:0] raddr_a,
   output logic [W-1:0] rdata_a,
   input wire logic [$clog2(DEPTH)-1:0] raddr_b,
   output logic [W-1:0] rdata_b
);
   logic [W-1:0] mem [DEPTH];
   // Storage has no reset; software loads it before enabling vectors.
   always_ff @(posedge clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end
   // Both read ports come out of registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_a <= '0;
         rdata_b <= '0;
      end else if (ce) begin
         rdata_a <= mem[raddr_a];
         rdata_b <= mem[raddr_b];
      end
   end
endmodule : ivc_vec_ram

/* File: rtl/ivc_ctrl.sv */
// Vectored interrupt controller: source selection, arrival and posted flags,
// priority evaluation, core handshake, nesting status and register port.
// Assumes source lines are asynchronous and the core handshake runs on sys_clk.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
module ivc_ctrl
   import ivc_pkg::*;
#(
   parameter int HADDR_W = 16
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [NUM_VEC-1:0] fixed_irq,
   input wire logic [DMA_GRP-1:0] dma_term_group_a,
   input wire logic [DMA_GRP-1:0] dma_term_group_b,
   input wire logic [NUM_VEC-1:0] fabric_irq,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic core_irq,
   output logic [4:0] core_vector,
   output logic [HADDR_W-1:0] core_handler_addr,
   input wire logic core_acknowledge,
   input wire logic return_from_handler_instr,
   output logic core_ack_phase,
   output logic service_complete,
   output logic irq_out
);
   if (HADDR_W < 1 || HADDR_W > 32) begin : g_chk
      $error("HADDR_W must lie between 1 and 32");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for every asynchronous source line.
   logic [3*NUM_VEC-1:0] raw_w;
   logic [3*NUM_VEC-1:0] s1_q;
   logic [3*NUM_VEC-1:0] s2_q;
   logic [NUM_VEC-1:0] src_prev_q;
   assign raw_w = {fabric_irq, dma_term_group_b, dma_term_group_a, fixed_irq};

   // Two flops per line; only the second stage is looked at.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else if (clk_en) begin
         s1_q <= raw_w;
         s2_q <= s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port decode.
   logic wr_en_w, wr_force_w, wr_clr_w, wr_evt_mask_w, wr_prio_w, wr_sel_w, wr_tab_w;
   logic rd_evt_w;
   assign wr_en_w = reg_wr && reg_addr == OFS_EN;
   assign wr_force_w = reg_wr && reg_addr == OFS_FORCE;
   assign wr_clr_w = reg_wr && reg_addr == OFS_CLR;
   assign wr_evt_mask_w = reg_wr && reg_addr == OFS_MASK;
   assign wr_prio_w = reg_wr && reg_addr[7:4] == OFS_PRIO_HI;
   assign wr_sel_w = reg_wr && reg_addr[7:4] == OFS_SEL_HI && reg_addr[3:2] < SEL_REGS;
   assign wr_tab_w = reg_wr && reg_addr[7];
   assign rd_evt_w = reg_rd && reg_addr == OFS_EVT;

   ////////////////////////////////////////////////////////////////////////////
   // Per-vector state and its next values.
   ivc_state_t st_q, st_d;
   logic [NUM_VEC-1:0] en_q, arr_q, arr_d, posted_flag_q, posted_flag_d, src_w;
   logic [NUM_VEC-1:0] elig_w, same_lo_w;
   logic [NUM_VEC*LVL_W-1:0] prio_q, prio_d;
   logic [NUM_VEC*SEL_W-1:0] sel_q, sel_d;
   logic [NUM_VEC*PRIO_STRIDE-1:0] prio_view_w;
   logic [LVL_W-1:0] prio_arr [NUM_VEC];
   logic [4:0] win_q;
   logic ack_take_w, posted_flag_clr_q;
   logic [3:0] ceil_w;
   ivc_arb_if #(.NV(NUM_VEC), .LW(LVL_W)) arb_if ();

   for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
      logic [1:0] sel_w;
      logic rise_w, set_w, clr_sw_w, serviced_w;
      assign sel_w = sel_q[v*SEL_W +: SEL_W];
      // Pick the source kind the vector is configured for.
      assign src_w[v] = (sel_w == SRC_FIXED) ? s2_q[v] :
                        (sel_w == SRC_DMA) ? s2_q[NUM_VEC + v] :
                        (sel_w == SRC_FABRIC) ? s2_q[2*NUM_VEC + v] : 1'b0;
      assign rise_w = src_w[v] && !src_prev_q[v];
      assign set_w = rise_w || (wr_force_w && reg_wdata[v]);
      assign clr_sw_w = wr_clr_w && reg_wdata[v];
      assign serviced_w = win_q == 5'(v);
      // A new arrival wins over any clear in the same cycle.
      assign arr_d[v] = set_w || (arr_q[v] && !clr_sw_w && !(ack_take_w && serviced_w));
      // Posted follows arrival one cycle later; service clears it a cycle after arrival.
      assign posted_flag_d[v] = (arr_q[v] && !clr_sw_w) ||
                         (posted_flag_q[v] && !clr_sw_w && !(posted_flag_clr_q && serviced_w));
      assign prio_d[v*LVL_W +: LVL_W] =
         (wr_prio_w && reg_addr[3:2] == 2'(v / PRIO_PER_REG)) ?
         reg_wdata[(v % PRIO_PER_REG)*PRIO_STRIDE +: LVL_W] : prio_q[v*LVL_W +: LVL_W];
      assign sel_d[v*SEL_W +: SEL_W] =
         (wr_sel_w && reg_addr[2] == 1'(v / SEL_PER_REG)) ?
         reg_wdata[(v % SEL_PER_REG)*SEL_W +: SEL_W] : sel_w;
      assign prio_arr[v] = prio_q[v*LVL_W +: LVL_W];
      assign prio_view_w[v*PRIO_STRIDE +: PRIO_STRIDE] = {1'b0, prio_arr[v]};
      // Only enabled, posted vectors above the running level compete.
      assign elig_w[v] = posted_flag_q[v] && en_q[v] && ({1'b0, prio_arr[v]} < ceil_w);
      assign same_lo_w[v] = elig_w[v] && prio_arr[v] == prio_arr[arb_if.win_idx] &&
                            5'(v) < arb_if.win_idx;
   end

   // Flag and configuration registers.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         arr_q <= '0;
         posted_flag_q <= '0;
         prio_q <= '0;
         sel_q <= '0;
         src_prev_q <= '0;
      end else if (clk_en) begin
         arr_q <= arr_d;
         posted_flag_q <= posted_flag_d;
         prio_q <= prio_d;
         sel_q <= sel_d;
         src_prev_q <= src_w;
      end
   end

   // Enable register, one bit per vector.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         en_q <= EN_RST;
      end else if (clk_en && wr_en_w) begin
         en_q <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Nesting status: one bit per level that has a handler running.
   logic [7:0] act_q, act_d, push_w;
   always_comb begin
      ceil_w = LVL_NONE;
      for (int i = 7; i >= 0; i--) begin
         if (act_q[i]) begin
            ceil_w = 4'(i);
         end
      end
   end
   assign push_w = ack_take_w ? 8'(8'h01 << prio_arr[win_q]) : 8'h00;
   // A return drops the most urgent running level, restoring the earlier status.
   assign act_d = (return_from_handler_instr ? (act_q & (act_q - 8'h01)) : act_q) | push_w;

   assign arb_if.eligible = elig_w;
   assign arb_if.lvl = prio_q;
   ivc_prio_arb u_arb (
      .a (arb_if)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Core handshake state machine.
   logic [2:0] cnt_q, cnt_d;
   logic win_ok_w;
   assign win_ok_w = posted_flag_q[win_q] && en_q[win_q];
   assign ack_take_w = st_q == IVC_REQ && win_ok_w && core_acknowledge;
   assign core_irq = st_q == IVC_REQ && win_ok_w;
   assign core_ack_phase = st_q == IVC_ACK;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         IVC_IDLE: begin
            cnt_d = 3'h0;
            if (arb_if.win_valid) begin
               st_d = IVC_EVAL;
            end
         end
         IVC_EVAL: begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == EVAL_CYC - 3'h1) begin
               st_d = arb_if.win_valid ? IVC_REQ : IVC_IDLE;
               cnt_d = 3'h0;
            end
         end
         IVC_REQ: begin
            if (!win_ok_w) begin
               st_d = IVC_IDLE;
            end else if (core_acknowledge) begin
               st_d = IVC_ACK;
            end
         end
         IVC_ACK: begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == ACK_CYC - 3'h1) begin
               st_d = IVC_IDLE;
               cnt_d = 3'h0;
            end
         end
         default: begin
            st_d = IVC_IDLE;
            cnt_d = 3'h0;
         end
      endcase
   end

   // State, winner and the delayed posted clear.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= IVC_IDLE;
         cnt_q <= 3'h0;
         win_q <= 5'h0;
         posted_flag_clr_q <= 1'b0;
         act_q <= 8'h00;
         service_complete <= 1'b0;
      end else if (clk_en) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         if (st_q == IVC_EVAL && st_d == IVC_REQ) begin
            win_q <= arb_if.win_idx;
         end
         posted_flag_clr_q <= ack_take_w;
         act_q <= act_d;
         service_complete <= return_from_handler_instr;
      end
   end
   assign core_vector = win_q;

   ////////////////////////////////////////////////////////////////////////////
   // Handler table: port A feeds the core, port B the register read.
   logic [HADDR_W-1:0] tab_b_w;
   logic tab_rd_q;
   ivc_vec_ram #(.DEPTH(NUM_VEC), .W(HADDR_W)) u_ram (
      .clk (sys_clk),
      .rst (sys_rst),
      .ce (clk_en),
      .we (wr_tab_w),
      .waddr (reg_addr[6:2]),
      .wdata (reg_wdata[HADDR_W-1:0]),
      .raddr_a (st_q == IVC_EVAL ? arb_if.win_idx : win_q),
      .rdata_a (core_handler_addr),
      .raddr_b (reg_addr[6:2]),
      .rdata_b (tab_b_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Event status, mask and interrupt output.
   logic [EVT_W-1:0] evt_q, evt_d, mask_q, evt_set_w;
   assign evt_set_w = {return_from_handler_instr, ack_take_w,
                       st_q == IVC_EVAL && st_d == IVC_REQ};
   // Read clears the status, but an event in the same cycle still lands.
   assign evt_d = (rd_evt_w ? '0 : evt_q) | evt_set_w;
   assign irq_out = |(evt_q & mask_q);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         evt_q <= '0;
         mask_q <= '0;
      end else if (clk_en) begin
         evt_q <= evt_d;
         if (wr_evt_mask_w) begin
            mask_q <= reg_wdata[EVT_W-1:0];
         end
      end
   end

   // Read data mux; unmapped offsets return zero.
   logic [31:0] rd_mux_w, rdata_q;
   assign rd_mux_w =
      (reg_addr == OFS_EN) ? en_q :
      (reg_addr == OFS_ARR) ? arr_q :
      (reg_addr == OFS_POSTED_FLAG) ? posted_flag_q :
      (reg_addr == OFS_ACT) ? {23'h0, core_ack_phase, act_q} :
      (reg_addr == OFS_EVT) ? {29'h0, evt_q} :
      (reg_addr == OFS_MASK) ? {29'h0, mask_q} :
      (reg_addr[7:4] == OFS_PRIO_HI) ? prio_view_w[reg_addr[3:2]*32 +: 32] :
      (reg_addr[7:4] == OFS_SEL_HI && reg_addr[3:2] < SEL_REGS) ?
         sel_q[reg_addr[2]*32 +: 32] : 32'h0;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 32'h0;
         tab_rd_q <= 1'b0;
      end else if (clk_en) begin
         rdata_q <= reg_rd ? rd_mux_w : 32'h0;
         tab_rd_q <= reg_rd && reg_addr[7];
      end
   end
   assign reg_rdata = tab_rd_q ? 32'(tab_b_w) : rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking dc @(posedge sys_clk iff clk_en); endclocking
   default disable iff (sys_rst);

   posted_flag_follows_arr_a: assert property (
      !wr_clr_w |=> ((($past(arr_q) & ~$past(posted_flag_q)) & ~posted_flag_q) == '0))
      else $error("posted flag did not follow arrival");
   eval_three_cyc_a: assert property (
      st_q == IVC_IDLE ##1 st_q == IVC_EVAL |-> (st_q == IVC_EVAL)[*3] ##1 st_q != IVC_EVAL)
      else $error("evaluation did not take three cycles");
   irq_vec_hold_a: assert property (
      core_irq ##1 core_irq |-> $stable(core_vector) && $stable(core_handler_addr))
      else $error("vector or handler address moved during request");
   ack_clear_order_a: assert property (
      ack_take_w && !wr_clr_w && !arr_d[win_q] |=>
         !arr_q[win_q] && posted_flag_q[win_q] ##1 !posted_flag_q[win_q])
      else $error("posted flag cleared before arrival flag");
   ack_phase_len_a: assert property (
      ack_take_w |=> core_ack_phase[*7] ##1 !core_ack_phase)
      else $error("acknowledge phase not seven cycles");
   done_restore_a: assert property (
      return_from_handler_instr && !ack_take_w |=>
         service_complete && act_q == ($past(act_q) & ($past(act_q) - 8'h01)))
      else $error("active status not restored on return");
   tie_lower_first_a: assert property (
      arb_if.win_valid |-> same_lo_w == '0)
      else $error("higher vector number won a tie");
   disabled_held_a: assert property (
      core_irq |-> en_q[core_vector])
      else $error("disabled vector forwarded to core");

   // Register effects and handshake edges.
   en_write_a: assert property (
      wr_en_w |=> en_q == $past(reg_wdata))
      else $error("enable write lost");
   force_sets_a: assert property (
      wr_force_w |=> (arr_q & $past(reg_wdata)) == $past(reg_wdata))
      else $error("force lost");
   clear_posted_flag_a: assert property (
      wr_clr_w |=> (posted_flag_q & $past(reg_wdata)) == '0)
      else $error("clear lost");
   win_latched_a: assert property (
      st_q == IVC_EVAL ##1 st_q == IVC_REQ |-> core_vector == $past(arb_if.win_idx))
      else $error("wrong vector forwarded");
   ack_from_req_a: assert property (
      $rose(core_ack_phase) |-> $past(ack_take_w))
      else $error("phase without acknowledge");
   done_after_ret_a: assert property (
      !return_from_handler_instr |=> !service_complete)
      else $error("completion without return");
endmodule : ivc_ctrl

/* File: sim/ivc_core_model.sv */
// Behavioural core: acknowledges requests, takes the handler address, returns on demand.
// Assumes it shares sys_clk with the controller and acts just after rising edges.
`timescale 1ns/1ns
module ivc_core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic core_irq,
   input wire logic [4:0] core_vector,
   input wire logic [15:0] core_handler_addr,
   input wire logic [3:0] ack_dly,
   input wire logic ret_req,
   output logic core_acknowledge,
   output logic return_from_handler_instr,
   output logic [4:0] last_vec,
   output logic [15:0] last_addr,
   output logic [3:0] depth
);
   logic [3:0] wait_q;
   ////////////////////////////////////////
   // Waits ack_dly cycles, acknowledges, then reads the handler address to branch.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_acknowledge <= 1'b0;
         return_from_handler_instr <= 1'b0;
         last_vec <= 5'h0;
         last_addr <= 16'h0;
         depth <= 4'h0;
         wait_q <= 4'h0;
      end else begin
         core_acknowledge <= 1'b0;
         return_from_handler_instr <= ret_req && depth != 4'h0;
         if (ret_req && depth != 4'h0) begin
            depth <= depth - 4'h1;
         end
         if (core_acknowledge && core_irq) begin
            last_vec <= core_vector;
            last_addr <= core_handler_addr;
            depth <= depth + 4'h1;
            wait_q <= 4'h0;
         end else if (core_irq && !core_acknowledge) begin
            if (wait_q == ack_dly) begin
               core_acknowledge <= 1'b1;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end else begin
            wait_q <= 4'h0;
         end
      end
   end
endmodule : ivc_core_model

/* File: sim/interrupt_vector_controller_bench.sv */
// Self-checking bench for the interrupt vector controller with a behavioural core.
// Assumes the package, interface, design files and core model are compiled first.
`timescale 1ns/1ns
module interrupt_vector_controller_bench;
   import ivc_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic [31:0] fixed_irq = 32'h0, fabric_irq = 32'h0, reg_wdata = 32'h0, reg_rdata;
   logic [15:0] dma_term_group_a = 16'h0, dma_term_group_b = 16'h0, core_handler_addr, last_addr;
   logic [7:0] reg_addr = 8'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, ret_req = 1'b0;
   logic core_irq, core_acknowledge, return_from_handler_instr;
   logic core_ack_phase, service_complete, irq_out;
   logic [4:0] core_vector, last_vec;
   logic [3:0] depth, ack_dly = 4'h0;
   int err_total = 0;
   int checks_done = 0;
   int first, acks;
   int vv[5] = '{2, 17, 30, 7, 0};
   logic [1:0] kk[5] = '{SRC_DMA, SRC_DMA, SRC_FABRIC, SRC_FIXED, 2'h3};

   // Free running system clock, 40 ns period.
   always #20 sys_clk = ~sys_clk;

   ivc_ctrl i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .fixed_irq(fixed_irq), .dma_term_group_a(dma_term_group_a),
      .dma_term_group_b(dma_term_group_b), .fabric_irq(fabric_irq), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_irq(core_irq), .core_vector(core_vector), .core_handler_addr(core_handler_addr),
      .core_acknowledge(core_acknowledge),
      .return_from_handler_instr(return_from_handler_instr),
      .core_ack_phase(core_ack_phase), .service_complete(service_complete), .irq_out(irq_out));

   ivc_core_model i_core (.clk(sys_clk), .rst(sys_rst), .core_irq(core_irq),
      .core_vector(core_vector), .core_handler_addr(core_handler_addr), .ack_dly(ack_dly),
      .ret_req(ret_req), .core_acknowledge(core_acknowledge),
      .return_from_handler_instr(return_from_handler_instr), .last_vec(last_vec),
      .last_addr(last_addr), .depth(depth));

   ////////////////////////////////////////
   // Handler address that the bench stores for vector v.
   function automatic logic [15:0] hnd(input int v);
      return 16'ha000 + 16'(v);
   endfunction : hnd

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Register write: one strobe cycle, then a quiet cycle; ends at a falling edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(negedge sys_clk);
   endtask : wr

   // Register read: data is looked at in the one cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(nm, exp, reg_rdata);
   endtask : rd

   // Waits for the core to take a request, then lets the acknowledge phase finish.
   task automatic take(input int v);
      logic [3:0] d;
      int n;
      d = depth;
      n = 0;
      while (depth === d && n < 60) begin
         @(negedge sys_clk);
         n++;
      end
      chk("take", 32'h1, 32'(depth !== d));
      chk("vector", 32'(v), {27'h0, last_vec});
      chk("handler", {16'h0, hnd(v)}, {16'h0, last_addr});
      repeat (9) @(negedge sys_clk);
   endtask : take

   // Asks the core to return and expects exactly one completion pulse.
   task automatic ret();
      int n;
      n = 0;
      @(posedge sys_clk);
      ret_req <= 1'b1;
      @(posedge sys_clk);
      ret_req <= 1'b0;
      repeat (6) begin
         @(negedge sys_clk);
         if (service_complete === 1'b1) n++;
      end
      chk("complete", 32'd1, 32'(n));
   endtask : ret

   // Raises the fixed (bit 0), DMA (bit 1) and fabric (bit 2) lines of vector v.
   task automatic drv(input int v, input logic [2:0] m);
      @(posedge sys_clk);
      fixed_irq <= m[0] ? (32'h1 << v) : 32'h0;
      dma_term_group_a <= (m[1] && v < 16) ? 16'(32'h1 << v) : 16'h0;
      dma_term_group_b <= (m[1] && v >= 16) ? 16'(32'h1 << (v - 16)) : 16'h0;
      fabric_irq <= m[2] ? (32'h1 << v) : 32'h0;
      repeat (6) @(negedge sys_clk);
   endtask : drv

   task automatic finish_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   ////////////////////////////////////////
   // Cuts a hang short well after the sequence should have ended.
   initial begin
      repeat (8000) @(posedge sys_clk);
      err_total++;
      finish_test();
   end

   // Main sequence of register calls and core traffic.
   initial begin
      logic [31:0] s;
      logic [2:0] own;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(OFS_EN, 32'h0, "enable");
      rd(8'h30, 32'h0, "select");
      rd(8'h40, 32'h0, "unmapped");
      for (int v = 0; v < 32; v++) wr(8'h80 + 8'(4 * v), {16'h0, hnd(v)});
      for (int r = 0; r < 4; r++) wr(8'h20 + 8'(4 * r), 32'h77777777);
      rd(8'h84, {16'h0, hnd(1)}, "table");
      wr(8'h20, 32'h77377777);
      wr(OFS_EN, 32'h20);
      wr(OFS_MASK, 32'h7);
      @(posedge sys_clk);
      fixed_irq <= 32'h20;
      first = 0;
      acks = 0;
      for (int i = 1; i <= 24; i++) begin
         @(negedge sys_clk);
         if (core_irq === 1'b1 && first == 0) first = i;
         if (core_ack_phase === 1'b1) acks++;
      end
      @(posedge sys_clk);
      fixed_irq <= 32'h0;
      chk("request delay", 32'd9, 32'(first));
      chk("ack phase", 32'd7, 32'(acks));
      chk("vector", 32'd5, {27'h0, last_vec});
      rd(OFS_ARR, 32'h0, "arrival");
      rd(OFS_POSTED_FLAG, 32'h0, "posted");
      rd(OFS_ACT, 32'h8, "active");
      chk("irq_out", 32'h1, {31'h0, irq_out});
      wr(OFS_MASK, 32'h0);
      @(negedge sys_clk);
      chk("irq_out", 32'h0, {31'h0, irq_out});
      wr(OFS_MASK, 32'h7);
      ret();
      rd(OFS_ACT, 32'h0, "active");
      rd(OFS_EVT, 32'h7, "events");
      rd(OFS_EVT, 32'h0, "events");
      @(negedge sys_clk);
      chk("irq_out", 32'h0, {31'h0, irq_out});
      wr(8'h20, 32'h77772777);
      wr(8'h24, 32'h77777727);
      wr(OFS_EN, 32'h208);
      ack_dly = 4'h3;
      wr(OFS_FORCE, 32'h208);
      take(3);
      ret();
      take(9);
      ret();
      wr(8'h24, 32'h77777627);
      wr(8'h28, 32'h77717777);
      wr(OFS_EN, 32'h100400);
      wr(OFS_FORCE, 32'h400);
      take(10);
      rd(OFS_ACT, 32'h40, "active");
      wr(OFS_FORCE, 32'h100000);
      take(20);
      rd(OFS_ACT, 32'h42, "active");
      ret();
      rd(OFS_ACT, 32'h40, "active");
      ret();
      wr(OFS_EN, 32'h0);
      wr(OFS_FORCE, 32'h1000);
      repeat (12) @(negedge sys_clk);
      rd(OFS_POSTED_FLAG, 32'h1000, "posted");
      chk("depth", 32'h0, {28'h0, depth});
      wr(OFS_EN, 32'h1000);
      take(12);
      ret();
      wr(OFS_EN, 32'h0);
      wr(OFS_FORCE, 32'h1000);
      wr(OFS_CLR, 32'h1000);
      rd(OFS_ARR, 32'h0, "arrival");
      rd(OFS_POSTED_FLAG, 32'h0, "posted");
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(OFS_FORCE, 32'h1000);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd(OFS_ARR, 32'h0, "frozen");
      for (int k = 0; k < 5; k++) begin
         s = 32'h0;
         s[(vv[k] % 16) * 2 +: 2] = kk[k];
         own = 3'(4'h1 << kk[k]);
         wr(vv[k] < 16 ? 8'h30 : 8'h34, s);
         drv(vv[k], ~own);
         rd(OFS_ARR, 32'h0, "other source");
         drv(vv[k], 3'h7);
         rd(OFS_ARR, own != 3'h0 ? 32'h1 << vv[k] : 32'h0, "source");
         drv(vv[k], 3'h0);
         wr(OFS_CLR, 32'hffffffff);
      end
      finish_test();
   end
endmodule : interrupt_vector_controller_bench
